//--- pkg/rmsc_pkg.sv
// Package for the reset manager and sleep control block
package rmsc_pkg;
	localparam logic [11:0] ADDR_CTRL  = 12'h000;
	localparam logic [11:0] ADDR_CAUSE = 12'h004;
	localparam logic [11:0] ADDR_WDOG  = 12'h008;

	localparam int CTRL_SLEEP_UNLOCK_BIT = 7;
	localparam int CTRL_PCFG_EN_BIT      = 6;
	localparam int CTRL_BADADDR_EN_BIT   = 5;
	localparam int CTRL_WDOG_EN_BIT      = 4;

	localparam int CAUSE_SLEEP_REQ_BIT = 7;
	localparam int CAUSE_BADADDR_BIT   = 5;
	localparam int CAUSE_WDOG_BIT      = 4;
	localparam int CAUSE_PORT_BIT      = 3;
	localparam int CAUSE_PIN_BIT       = 2;
	localparam int CAUSE_PIN_SLEEP_BIT = 1;

	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] CAUSE_RESET = 8'h00;
	localparam logic [3:0] WDOG_RESET  = 4'h0;
	localparam logic [3:0] KEY_FIRST   = 4'hA;
	localparam logic [3:0] KEY_SECOND  = 4'h3;
	localparam logic [3:0] WDOG_LIMIT  = 4'h8;

	// Watchdog tick period at 50 MHz; 2 s maximum timeout across 8 steps
	localparam int CLK_HZ         = 50000000;
	localparam int WDOG_TIMEOUT_MS = 2000;
	localparam int WDOG_TICK_CYC  = (CLK_HZ / 1000) * (WDOG_TIMEOUT_MS / 8);

	typedef enum logic [1:0] {
		KEY_IDLE = 2'b00,
		KEY_ARMED = 2'b01
	} rmsc_key_t;
endpackage

//--- pkg/rmsc_sync_if.sv
// Interface carrying raw and synchronised reset request inputs
`timescale 1ns/10ps
interface rmsc_sync_if;
	logic pin_raw;
	logic port_raw;
	logic pin_sync;
	logic port_sync;
	modport src (output pin_raw, output port_raw, input pin_sync, input port_sync);
	modport sync (input pin_raw, input port_raw, output pin_sync, output port_sync);
endinterface

//--- rtl/rmsc_sync.sv
// Two flip-flop synchroniser for the external reset requests
`timescale 1ns/10ps
module rmsc_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	rmsc_sync_if.sync s
);
	logic [1:0] meta_r;
	logic [1:0] sync_r;

	// R23: sync requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_r <= 2'h0;
			sync_r <= 2'h0;
		end else begin
			meta_r <= {s.port_raw, s.pin_raw};
			sync_r <= meta_r;
		end
	end

	assign s.pin_sync  = sync_r[0];
	assign s.port_sync = sync_r[1];
endmodule

//--- rtl/rmsc_top.sv
// Reset manager with cause flags, sleep lock and watchdog
// What this block does
// R1: Control bit 7 unlocks sleep; cold reset clears it; locked means no sleep.
// R2: Control bit 6 lets port-config reset follow system reset, non-cold sources.
// R3: Control bit 5 enabled, bad address access gives system reset.
// R4: Control bit 4 enables watchdog reset; software cannot clear it.
// R5: Cause bit 7 write enters sleep if unlocked; reads 0; system reset clears.
// R6: Cause flags: 5 bad address, 4 watchdog, 3 port, 2 pin, 1 pin-in-sleep.
// R7: Flags accumulate; cleared by power-on reset or any write to cause register.
// R8: After power-on all cause flags read zero.
// R9: Pin wake from sleep sets both pin flag and pin-in-sleep flag.
// R10: Watchdog register low nibble is key on write, counter on read.
// R11: Cold reset comes from power-on, and from the reset pin in the later variant; no other sources.
// R12: System reset follows cold reset or any enabled source, not sleep.
// R13: Port-config reset for soft sources only when enabled; always for power-on.
// R14: Sleep reset holds throughout sleep and during power-on.
// R15: Reset pin request is active high.
// R16: Power-on reset releases only once regulator is ready.
// R17: Watchdog timeout with enable set gives system reset and flag.
// R18: Sleep request drives only the sleep reset.
// R19: Later variant pin asserts all four resets; earlier only system, and pconf when control bit 6 is set.
// R20: Watchdog cleared by key 0x0A then 0x03; other write cancels.
// R21: Watchdog counts 0 to 7; reaching 8 resets the system when control bit 4 is set.
// R22: Bad address fault comes from the address decoder miss signal.
// R23: Pin and port requests synchronised before setting flags.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module rmsc_top #(
	parameter bit LATER_VARIANT = 1'b1,
	parameter int TICK_CYC      = rmsc_pkg::WDOG_TICK_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        regulator_ready,
	input  wire logic        reset_pin,
	input  wire logic        port_combo_req,
	input  wire logic        bad_address_fault,
	output logic             reset_cold,
	output logic             reset_system,
	output logic             reset_port_cfg,
	output logic             reset_sleep,
	output logic             sleep_mode
);
	import rmsc_pkg::*;

	logic       por_r;
	logic       sleep_r;
	logic [7:0] ctrl_r;
	logic [7:0] cause_r;
	logic [7:0] cause_nxt;
	logic [3:0] wd_count_r;
	logic [3:0] wd_count_nxt;
	rmsc_key_t  key_r;
	rmsc_key_t  key_nxt;
	logic [31:0] tick_cnt_r;
	logic       wd_fire_r;
	logic       cold_r;
	logic       sys_r;
	logic       pcfg_r;
	logic       slp_r;
	logic [31:0] prdata_r;
	logic       pready_r;
	logic       pslverr_r;

	rmsc_sync_if sif ();
	assign sif.pin_raw  = reset_pin;
	assign sif.port_raw = port_combo_req;

	rmsc_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.s       (sif)
	);

	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] r);
		return a == r;
	endfunction

	// Decode
	wire acc       = psel && penable;
	wire wr_acc    = acc && pwrite;
	wire hit_ctrl  = is_reg(paddr, ADDR_CTRL);
	wire hit_cause = is_reg(paddr, ADDR_CAUSE);
	wire hit_wdog  = is_reg(paddr, ADDR_WDOG);
	wire hit_any   = hit_ctrl || hit_cause || hit_wdog;
	wire wr_ctrl   = wr_acc && hit_ctrl;
	wire wr_cause  = wr_acc && hit_cause;
	wire wr_wdog   = wr_acc && hit_wdog;
	wire [3:0] key_in = pwdata[3:0];

	// R15: active-high pin
	wire pin_req  = sif.pin_sync;
	wire port_req = sif.port_sync;
	// R3: enabled bad address source
	// R22: decoder miss input
	wire bad_req  = ctrl_r[CTRL_BADADDR_EN_BIT] && bad_address_fault;
	// R17: enabled watchdog source
	wire wd_req   = ctrl_r[CTRL_WDOG_EN_BIT] && wd_fire_r;
	// R19: variant choice for the pin
	wire pin_cold = LATER_VARIANT && pin_req;
	// R11: cold from power-on or later-variant pin only
	wire cold_src = por_r || pin_cold;
	wire soft_src = pin_req || port_req || wd_req || bad_req;
	// R12: system from cold or any enabled source
	wire sys_src  = cold_src || soft_src;
	// R13: port-config gated for soft sources
	// R2: enable bit steers it
	wire pcfg_src = cold_src || (soft_src && ctrl_r[CTRL_PCFG_EN_BIT]);
	// R14: sleep reset during sleep and power-on
	// R18: sleep drives only this one
	wire slp_src  = cold_src || sleep_r;
	// R1: lock gates sleep request
	// R5: enter sleep on unlocked write
	wire sleep_go = wr_cause && pwdata[CAUSE_SLEEP_REQ_BIT] && ctrl_r[CTRL_SLEEP_UNLOCK_BIT];

	// R16: power-on held until regulator ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			por_r <= 1'b1;
		else if (regulator_ready)
			por_r <= 1'b0;
	end

	// Control register; wakes by port combo keep it
	// R4: watchdog enable sticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_r <= CTRL_RESET;
		else if (cold_src)
			ctrl_r <= CTRL_RESET;
		else if (wr_ctrl)
			ctrl_r <= {pwdata[7:5], pwdata[4] | ctrl_r[CTRL_WDOG_EN_BIT], 4'h0};
	end

	// Sleep stays until a system-level reset wakes the device
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sleep_r <= 1'b0;
		else if (sys_src)
			sleep_r <= 1'b0;
		else if (sleep_go)
			sleep_r <= 1'b1;
	end

	// R6: flag per source
	// R7: accumulate, write clears, set wins
	// R9: pin wake sets both flags
	always_comb begin
		cause_nxt = wr_cause ? 8'h00 : cause_r;
		if (bad_req)
			cause_nxt[CAUSE_BADADDR_BIT] = 1'b1;
		if (wd_req)
			cause_nxt[CAUSE_WDOG_BIT] = 1'b1;
		if (port_req)
			cause_nxt[CAUSE_PORT_BIT] = 1'b1;
		if (pin_req)
			cause_nxt[CAUSE_PIN_BIT] = 1'b1;
		if (pin_req && sleep_r)
			cause_nxt[CAUSE_PIN_SLEEP_BIT] = 1'b1;
		cause_nxt[7] = 1'b0;
		cause_nxt[6] = 1'b0;
		cause_nxt[0] = 1'b0;
	end

	// R8: power-on leaves all flags zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cause_r <= CAUSE_RESET;
		else if (por_r)
			cause_r <= CAUSE_RESET;
		else
			cause_r <= cause_nxt;
	end

	// Tick divider; watchdog clock is stopped during sleep
	wire tick = (tick_cnt_r == 32'(TICK_CYC - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			tick_cnt_r <= 32'h0;
		else if (tick || sleep_r)
			tick_cnt_r <= 32'h0;
		else
			tick_cnt_r <= tick_cnt_r + 32'h1;
	end

	// R20: two-step key sequence
	wire key_clear = wr_wdog && (key_r == KEY_ARMED) && (key_in == KEY_SECOND);
	always_comb begin
		key_nxt = key_r;
		case (key_r)
			KEY_IDLE:  key_nxt = (wr_wdog && key_in == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
			KEY_ARMED: if (wr_wdog) key_nxt = (key_in == KEY_FIRST) ? KEY_ARMED : KEY_IDLE;
			default:   key_nxt = KEY_IDLE;
		endcase
	end

	// R21: count 0..7, reaching 8 fires
	always_comb begin
		wd_count_nxt = wd_count_r;
		if (key_clear || wd_fire_r)
			wd_count_nxt = WDOG_RESET;
		else if (tick && !sleep_r)
			wd_count_nxt = wd_count_r + 4'h1;
	end

	// R10: counter cleared on cold reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_count_r <= WDOG_RESET;
			key_r      <= KEY_IDLE;
		end else if (cold_src) begin
			wd_count_r <= WDOG_RESET;
			key_r      <= KEY_IDLE;
		end else begin
			wd_count_r <= wd_count_nxt;
			key_r      <= key_nxt;
		end
	end

	// R17: timeout pulse when the count reaches 8
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			wd_fire_r <= 1'b0;
		else
			wd_fire_r <= (wd_count_nxt == WDOG_LIMIT);
	end

	// Registered reset outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cold_r <= 1'b1;
			sys_r  <= 1'b1;
			pcfg_r <= 1'b1;
			slp_r  <= 1'b1;
		end else begin
			cold_r <= cold_src;
			sys_r  <= sys_src;
			pcfg_r <= pcfg_src;
			slp_r  <= slp_src;
		end
	end

	// R10: read returns the counter
	// R5: sleep bit reads zero
	wire [31:0] rd_mux = hit_ctrl  ? {24'h0, ctrl_r} :
	                     hit_cause ? {24'h0, cause_r} :
	                     hit_wdog  ? {28'h0, wd_count_r} : 32'h0;

	// No wait state: answer comes in the access cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= psel && !penable;
			pslverr_r <= psel && !penable && !hit_any;
			prdata_r  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
		end
	end

	assign prdata         = prdata_r;
	assign pready         = pready_r;
	assign pslverr        = pslverr_r;
	assign reset_cold     = cold_r;
	assign reset_system   = sys_r;
	assign reset_port_cfg = pcfg_r;
	assign reset_sleep    = slp_r;
	assign sleep_mode     = sleep_r;

	// R1: locked sleep request never sleeps
	a_sleep_lock: assert property (@(posedge pclk) disable iff (!presetn) // R1
		(wr_cause && pwdata[7] && !ctrl_r[7] && !sleep_r) |=> !sleep_r)
		else $error("sleep entered while locked");
	// R4: enable bit never falls without cold reset
	a_wdog_sticky: assert property (@(posedge pclk) disable iff (!presetn) // R4
		($past(ctrl_r[4]) && !$past(cold_src)) |-> ctrl_r[4])
		else $error("watchdog enable cleared");
	// R7: write clears flags
	a_cause_clear: assert property (@(posedge pclk) disable iff (!presetn) // R7
		(wr_cause && !soft_src) |=> cause_r == 8'h00)
		else $error("cause not cleared");
	// R9: pin in sleep sets both
	a_pin_sleep: assert property (@(posedge pclk) disable iff (!presetn) // R9
		(pin_req && sleep_r && !por_r) |=> cause_r[2] && cause_r[1])
		else $error("pin wake flags missing");
	// R12: system reset follows sources
	a_sys_follow: assert property (@(posedge pclk) disable iff (!presetn) // R12
		soft_src |=> reset_system)
		else $error("system reset missing");
	// R18: sleep alone not system reset
	a_sleep_only: assert property (@(posedge pclk) disable iff (!presetn) // R18
		(sleep_r && !sys_src) |=> !reset_system && reset_sleep)
		else $error("sleep drove wrong reset");
	// R13: pconf gated by enable
	a_pcfg_gate: assert property (@(posedge pclk) disable iff (!presetn) // R13
		(!cold_src && !ctrl_r[6]) |=> !reset_port_cfg)
		else $error("port config reset without enable");
	// R21: counter stays below 9
	a_wd_range: assert property (@(posedge pclk) disable iff (!presetn) // R21
		wd_count_r <= 4'h8)
		else $error("watchdog count out of range");
	// R20: correct key pair clears the count
	a_key_clear: assert property (@(posedge pclk) disable iff (!presetn) // R20
		(key_clear && !cold_src) |=> wd_count_r == 4'h0)
		else $error("key pair did not clear");
	// R11: cold only from power-on or pin
	a_cold_src: assert property (@(posedge pclk) disable iff (!presetn) // R11
		(!por_r && !pin_req) |=> !reset_cold)
		else $error("cold reset from wrong source");
	// R14: power-on raises all four
	a_por_resets: assert property (@(posedge pclk) disable iff (!presetn) // R14
		por_r |=> reset_cold && reset_system && reset_port_cfg && reset_sleep)
		else $error("power-on did not assert every reset");
	// R17: enabled timeout resets and flags
	a_wd_timeout: assert property (@(posedge pclk) disable iff (!presetn) // R17
		(wd_fire_r && ctrl_r[CTRL_WDOG_EN_BIT]) |=> reset_system && cause_r[CAUSE_WDOG_BIT])
		else $error("watchdog timeout without reset or flag");
	// R6: pin request latches its flag
	a_pin_flag: assert property (@(posedge pclk) disable iff (!presetn) // R6
		(pin_req && !por_r) |=> cause_r[CAUSE_PIN_BIT])
		else $error("pin flag not latched");
	// R2: enabled port config follows soft sources
	a_pcfg_follow: assert property (@(posedge pclk) disable iff (!presetn) // R2
		(soft_src && ctrl_r[CTRL_PCFG_EN_BIT]) |=> reset_port_cfg)
		else $error("port config reset missing");
	// R19: later variant pin gives cold reset
	a_cold_pin: assert property (@(posedge pclk) disable iff (!presetn) // R19
		(pin_req && LATER_VARIANT) |=> reset_cold)
		else $error("pin did not give cold reset");
	// R5: system-level reset ends sleep
	a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn) // R5
		sys_src |=> !sleep_mode)
		else $error("sleep survived system reset");

	c_sleep: cover property (@(posedge pclk) disable iff (!presetn) sleep_go);
	c_wd_fire: cover property (@(posedge pclk) disable iff (!presetn) wd_req);
	c_key: cover property (@(posedge pclk) disable iff (!presetn) key_clear);
	c_pin_wake: cover property (@(posedge pclk) disable iff (!presetn) pin_req && sleep_r);
	c_pcfg: cover property (@(posedge pclk) disable iff (!presetn) soft_src && ctrl_r[6]);
endmodule

//--- test/rmsc_far_end.sv
// Model of the processor-side logic that raises reset requests
`timescale 1ns/10ps
module rmsc_far_end (
	input  wire logic pclk,
	output logic      reset_pin,
	output logic      port_combo_req,
	output logic      bad_address_fault,
	output logic      regulator_ready
);
	logic [3:0] req_r;

	initial begin
		req_r = 4'h0;
	end
	assign reset_pin         = req_r[0];
	assign port_combo_req    = req_r[1];
	assign bad_address_fault = req_r[2];
	assign regulator_ready   = req_r[3];

	// Lines change just after an edge, like real logic
	task drive(input int src, input logic v);
		@(posedge pclk);
		req_r[src] <= v;
	endtask
endmodule

//--- test/reset_manager_sleep_control_test.sv
// Self-checking bench for the reset manager
`timescale 1ns/10ps
module reset_manager_sleep_control_test;
	import rmsc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        reset_pin, port_combo_req, bad_address_fault, regulator_ready;
	logic        reset_cold, reset_system, reset_port_cfg, reset_sleep, sleep_mode;
	int          mismatches = 0;
	int          check_count = 0;
	int          k;
	localparam logic [11:0] T_A [4] = '{ADDR_CTRL, ADDR_CTRL, ADDR_CAUSE, 12'h00C};
	localparam logic [31:0] T_W [4] = '{32'hFFFFFFEF, 32'h0, 32'h0, 32'hFF};
	localparam logic [31:0] T_E [4] = '{32'hE0, 32'h0, 32'h0, 32'h0};

	rmsc_top #(.LATER_VARIANT(1'b1), .TICK_CYC(64)) i_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .regulator_ready(regulator_ready),
		.reset_pin(reset_pin), .port_combo_req(port_combo_req),
		.bad_address_fault(bad_address_fault), .reset_cold(reset_cold),
		.reset_system(reset_system), .reset_port_cfg(reset_port_cfg),
		.reset_sleep(reset_sleep), .sleep_mode(sleep_mode)
	);
	rmsc_far_end i_far (
		.pclk(pclk), .reset_pin(reset_pin), .port_combo_req(port_combo_req),
		.bad_address_fault(bad_address_fault), .regulator_ready(regulator_ready)
	);

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	task tally_and_finish();
		if (mismatches == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task tmo();
		chk(32'hFFFFFFFF, 32'h0);
		tally_and_finish();
	endtask
	// Request held until pready seen at a rising edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		if (k == 50) tmo();
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk(rd, e);
	endtask
	task wait_sys(input logic v);
		k = 0;
		while (reset_system !== v && k < 2000) begin
			@(posedge pclk);
			k++;
		end
		if (k == 2000) tmo();
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (10) @(posedge pclk);
		chk({reset_cold, reset_system, reset_port_cfg, reset_sleep, sleep_mode}, 32'h1E);
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		repeat (10) @(posedge pclk);
		chk({reset_cold, reset_system, reset_port_cfg, reset_sleep, sleep_mode}, 32'h1E);
		i_far.drive(3, 1'h1);
		wait_sys(1'h0);
		rchk(ADDR_CAUSE, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, T_A[i], T_W[i]);
			rchk(T_A[i], T_E[i]);
			chk(err, T_A[i] == 12'h00C);
		end
		// Locked sleep request is ignored
		apb(1'h1, ADDR_CAUSE, 32'h80);
		repeat (3) @(posedge pclk);
		chk(sleep_mode, 32'h0);
		apb(1'h1, ADDR_CTRL, 32'h80);
		apb(1'h1, ADDR_CAUSE, 32'h80);
		repeat (3) @(posedge pclk);
		chk({sleep_mode, reset_sleep, reset_system, reset_cold}, 32'hC);
		i_far.drive(0, 1'h1);
		repeat (8) @(posedge pclk);
		chk({reset_cold, reset_system, reset_port_cfg}, 32'h7);
		i_far.drive(0, 1'h0);
		wait_sys(1'h0);
		chk(sleep_mode, 32'h0);
		rchk(ADDR_CAUSE, 32'h06);
		rchk(ADDR_CTRL, 32'h0); // cold clears
		// Port request without and with port-config enable
		for (int i = 0; i < 2; i++) begin
			apb(1'h1, ADDR_CTRL, i ? 32'h40 : 32'h0);
			i_far.drive(1, 1'h1);
			repeat (6) @(posedge pclk);
			chk({reset_cold, reset_system, reset_port_cfg}, i ? 32'h3 : 32'h2);
			i_far.drive(1, 1'h0);
			wait_sys(1'h0);
		end
		rchk(ADDR_CAUSE, 32'h0E); // accumulate
		apb(1'h1, ADDR_CAUSE, 32'h55);
		rchk(ADDR_CAUSE, 32'h0); // clear
		// Bad address, disabled then enabled
		for (int i = 0; i < 2; i++) begin
			apb(1'h1, ADDR_CTRL, i ? 32'h20 : 32'h0);
			i_far.drive(2, 1'h1);
			i_far.drive(2, 1'h0);
			// One-cycle fault gives a one-cycle reset, seen at the next edge
			@(posedge pclk);
			chk(reset_system, i);
			wait_sys(1'h0);
			rchk(ADDR_CAUSE, i ? 32'h20 : 32'h0);
		end
		apb(1'h1, ADDR_CAUSE, 32'h0);
		apb(1'h1, ADDR_CTRL, 32'h10);
		apb(1'h1, ADDR_CTRL, 32'h0);
		rchk(ADDR_CTRL, 32'h10); // sticky
		// Service with and without a stray write between keys
		for (int i = 0; i < 2; i++) begin
			apb(1'h0, ADDR_WDOG, 32'h0);
			for (int n = 0; n < 100 && rd < 3; n++) apb(1'h0, ADDR_WDOG, 32'h0);
			chk(rd < 8, 32'h1);
			apb(1'h1, ADDR_WDOG, 32'h0A);
			if (i) apb(1'h1, ADDR_WDOG, 32'h05);
			apb(1'h1, ADDR_WDOG, 32'h03);
			apb(1'h0, ADDR_WDOG, 32'h0);
			chk(rd < 2, !i);
		end
		wait_sys(1'h1);
		wait_sys(1'h0);
		rchk(ADDR_CAUSE, 32'h10);
		// Second power-on while a flag and the watchdog enable are set
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		rchk(ADDR_CAUSE, 32'h0);
		rchk(ADDR_CTRL, 32'h0);
		tally_and_finish();
	end
endmodule
